// File: three_channel_adc_register_map.sv
`timescale 1ns/1ps
`default_nettype none
module three_channel_adc_register_map
#(
   parameter int          READY_CYCLES    = adc_regs_pkg::READY_CYCLES,
   parameter logic [6:0]  DREADY_CYCLES   = 7'(adc_regs_pkg::DREADY_CYCLES),
   // arbitrary value
   parameter logic [2:0]  SILICON_VERSION = 3'h1
)
(
   input  wire logic                                clk,
   input  wire logic                                reset,
   input  wire logic                                sclk,
   input  wire logic                                cs_n,
   input  wire logic                                mosi,
   output logic                                     miso,
   output logic                                     miso_oe,
   input  wire logic                                sample_valid,
   input  wire logic [adc_regs_pkg::SAMPLE_W-1:0]   current_in,
   input  wire logic [adc_regs_pkg::SAMPLE_W-1:0]   voltage_one_in,
   input  wire logic [adc_regs_pkg::SAMPLE_W-1:0]   voltage_two_in,
   input  wire logic [7:0]                          temp_offset_in,
   output logic                                     drdy_n,
   output logic                                     adc_sync,
   output logic                                     soft_reset,
   output logic                                     clkout_en,
   output logic                                     temp_en,
   output logic [1:0]                               adc_freq,
   output logic                                     filter_bw
);
   import adc_regs_pkg::*;

   localparam int READY_W = $clog2(READY_CYCLES + 1);
   localparam logic [READY_W-1:0] READY_LAST = READY_W'(READY_CYCLES - 1);

   typedef struct packed {
      logic [23:0]        current_sample;
      logic [23:0]        voltage_one_sample;
      logic [23:0]        voltage_two_sample;
      logic [15:0]        sample_crc;
      logic [15:0]        config_crc;
      logic               config_crc_valid;
      logic [15:0]        sync_count_capture;
      logic [11:0]        align_count;
      logic [7:0]         setup_control;
      logic [7:0]         write_protect_key;
      logic [7:0]         align_trigger;
      logic [7:0]         temp_sensor_offset;
      logic               reset_on;
      logic               crc_stat;
      logic               ic_prot;
      logic [READY_W-1:0] ready_cnt;
      logic [6:0]         dready_cnt;
      logic               drdy_n;
      logic               adc_sync;
      logic               soft_reset;
      logic               rd_ready;
      logic [23:0]        rd_word;
      logic [4:0]         rd_len;
   } bank_state_t;

   localparam bank_state_t BANK_RESET = '{reset_on: 1'b1, drdy_n: 1'b1,
                                          setup_control: SETUP_RESET, default: '0};

   bank_state_t st;
   bank_state_t next_st;
   spi_link_if  link ();
   logic [15:0] cfg_crc;
   logic [4:0]  read_addr;
   logic [28:0] read_val;

   // ------------------------------------------------------------
   // crc helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] crc16_update(input logic [15:0] crc,
                                                input logic [7:0]  data);
      logic [15:0] c;
      c = crc ^ {data, 8'h00};
      for (int i = 0; i < 8; i++)
      begin
         if (c[15])
            c = {c[14:0], 1'b0} ^ CRC_POLY;
         else
            c = {c[14:0], 1'b0};
      end
      return c;
   endfunction : crc16_update

   function automatic logic [15:0] crc16_samples(input logic [71:0] data);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 8; i >= 0; i--)
         c = crc16_update(c, data[i*8 +: 8]);
      return c;
   endfunction : crc16_samples

   // ------------------------------------------------------------
   // read path helpers
   // ------------------------------------------------------------
   function automatic logic [4:0] burst_addr(input logic [2:0] idx);
      case (idx)
         3'h0:    return ADDR_CURRENT;
         3'h1:    return ADDR_VOLT_ONE;
         3'h2:    return ADDR_VOLT_TWO;
         3'h3:    return ADDR_SAMPLE_CRC;
         3'h4:    return ADDR_CAPTURE;
         3'h5:    return ADDR_PRIMARY;
         default: return ADDR_UNBACKED;
      endcase
   endfunction : burst_addr

   // length in the top five bits, data aligned to bit 23
   function automatic logic [28:0] read_reg(input bank_state_t s, input logic [4:0] addr);
      case (addr)
         ADDR_CURRENT:    return {LEN_24, s.current_sample};
         ADDR_VOLT_ONE:   return {LEN_24, s.voltage_one_sample};
         ADDR_VOLT_TWO:   return {LEN_24, s.voltage_two_sample};
         ADDR_RSVD_24:    return {LEN_24, 24'h000000};
         ADDR_SAMPLE_CRC: return {LEN_16, s.sample_crc, 8'h00};
         ADDR_CONFIG_CRC: return {LEN_16, s.config_crc, 8'h00};
         ADDR_RSVD_16:    return {LEN_16, 16'h0000, 8'h00};
         ADDR_CAPTURE:    return {LEN_16, s.sync_count_capture, 8'h00};
         ADDR_SETUP:      return {LEN_8, s.setup_control, 16'h0000};
         ADDR_PRIMARY:    return {LEN_8, 5'h00, s.ic_prot, s.crc_stat, s.reset_on,
                                  16'h0000};
         ADDR_COUNT_LOW:  return {LEN_8, s.align_count[7:0], 16'h0000};
         ADDR_COUNT_HIGH: return {LEN_8, 4'h0, s.align_count[11:8], 16'h0000};
         ADDR_RSVD_FF:    return {LEN_8, RSVD_FF_VALUE, 16'h0000};
         ADDR_SECONDARY:  return {LEN_8, 5'h00, SILICON_VERSION, 16'h0000};
         ADDR_TEMP_OFS:   return {LEN_8, s.temp_sensor_offset, 16'h0000};
         default:         return {LEN_8, 24'h000000};
      endcase
   endfunction : read_reg

   // ------------------------------------------------------------
   // serial port
   // ------------------------------------------------------------
   spi_port u_spi_port
   (
      .clk     (clk),
      .reset   (reset),
      .sclk    (sclk),
      .cs_n    (cs_n),
      .mosi    (mosi),
      .miso    (miso),
      .miso_oe (miso_oe),
      .link    (link)
   );

   // ------------------------------------------------------------
   // register bank next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_st            = st;
      next_st.rd_ready   = 1'b0;
      next_st.adc_sync   = 1'b0;
      next_st.soft_reset = 1'b0;
      next_st.align_trigger      = 8'h00;
      next_st.temp_sensor_offset = temp_offset_in;
      next_st.align_count        = st.align_count + 12'h001;
      cfg_crc   = crc16_update(crc16_update(CRC_INIT, st.setup_control),
                               {7'h00, st.ic_prot});
      read_addr = ADDR_UNBACKED;
      read_val  = '0;

      // startup: primary flag bit 0 clears once the ready time is over
      if (st.reset_on)
      begin
         if (st.ready_cnt == READY_LAST)
            next_st.reset_on = 1'b0;
         else
            next_st.ready_cnt = st.ready_cnt + READY_W'(1);
      end

      // new conversion results and data-ready strobe
      if (sample_valid)
      begin
         next_st.current_sample     = current_in;
         next_st.voltage_one_sample = voltage_one_in;
         next_st.voltage_two_sample = voltage_two_in;
         next_st.sample_crc = crc16_samples({current_in, voltage_one_in,
                                             voltage_two_in});
         next_st.dready_cnt = DREADY_CYCLES;
         next_st.drdy_n     = st.setup_control[CFG_CLKOUT_EN];
      end
      else if (st.dready_cnt != 7'h00)
      begin
         next_st.dready_cnt = st.dready_cnt - 7'h01;
         if (st.dready_cnt == 7'h01)
            next_st.drdy_n = 1'b1;
      end

      // read fetch, burst sequence when starting at address zero
      if (link.fetch)
      begin
         if (link.fetch_addr == ADDR_CURRENT)
            read_addr = burst_addr(link.fetch_idx);
         else if (link.fetch_idx == 3'h0)
            read_addr = link.fetch_addr;
         else
            read_addr = ADDR_UNBACKED;
         read_val         = read_reg(st, read_addr);
         next_st.rd_ready = 1'b1;
         next_st.rd_len   = read_val[28:24];
         next_st.rd_word  = read_val[23:0];
         // reading the primary flags clears the crc change flag
         if (read_addr == ADDR_PRIMARY)
            next_st.crc_stat = 1'b0;
      end

      // configuration crc tracking, a change sets the flag over a clear
      next_st.config_crc       = cfg_crc;
      next_st.config_crc_valid = 1'b1;
      if (st.config_crc_valid && cfg_crc != st.config_crc)
         next_st.crc_stat = 1'b1;

      // host writes
      if (link.wr_valid)
      begin
         case (link.wr_addr)
            ADDR_KEY:
            begin
               next_st.write_protect_key = link.wr_data;
               if (link.wr_data == KEY_UNLOCK)
                  next_st.ic_prot = 1'b0;
               else if (link.wr_data == KEY_LOCK)
                  next_st.ic_prot = 1'b1;
            end
            ADDR_ALIGN:
            begin
               next_st.align_trigger = link.wr_data;
               if (link.wr_data[ALIGN_SYNC_BIT])
               begin
                  next_st.adc_sync           = 1'b1;
                  next_st.sync_count_capture = {4'h0, st.align_count};
               end
            end
            ADDR_SETUP:
            begin
               if (!st.ic_prot)
                  next_st.setup_control = link.wr_data;
            end
            ADDR_COUNT_LOW:
               next_st.align_count[7:0] = link.wr_data;
            ADDR_COUNT_HIGH:
               next_st.align_count[11:8] = link.wr_data[3:0];
            default:
               next_st.align_trigger = 8'h00;
         endcase
      end

      // software reset restores every default and self-clears
      if (next_st.setup_control[CFG_SWRST])
      begin
         next_st            = BANK_RESET;
         next_st.soft_reset = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         st <= BANK_RESET;
      else
         st <= next_st;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign link.rd_ready = st.rd_ready;
   assign link.rd_word  = st.rd_word;
   assign link.rd_len   = st.rd_len;
   assign drdy_n        = st.drdy_n;
   assign adc_sync      = st.adc_sync;
   assign soft_reset    = st.soft_reset;
   assign clkout_en     = st.setup_control[CFG_CLKOUT_EN];
   assign temp_en       = st.setup_control[CFG_TEMP_EN];
   assign adc_freq      = st.setup_control[CFG_FREQ_LSB +: 2];
   assign filter_bw     = st.setup_control[CFG_BW];
endmodule : three_channel_adc_register_map
`default_nettype wire

// File: adc_regs_pkg.sv
`default_nettype none
package adc_regs_pkg;
   localparam int         SAMPLE_W        = 24;
   localparam logic [4:0] ADDR_CURRENT    = 5'h00;
   localparam logic [4:0] ADDR_VOLT_ONE   = 5'h01;
   localparam logic [4:0] ADDR_VOLT_TWO   = 5'h02;
   localparam logic [4:0] ADDR_RSVD_24    = 5'h03;
   localparam logic [4:0] ADDR_SAMPLE_CRC = 5'h04;
   localparam logic [4:0] ADDR_CONFIG_CRC = 5'h05;
   localparam logic [4:0] ADDR_RSVD_16    = 5'h06;
   localparam logic [4:0] ADDR_CAPTURE    = 5'h07;
   localparam logic [4:0] ADDR_SETUP      = 5'h08;
   localparam logic [4:0] ADDR_PRIMARY    = 5'h09;
   localparam logic [4:0] ADDR_KEY        = 5'h0A;
   localparam logic [4:0] ADDR_ALIGN      = 5'h0B;
   localparam logic [4:0] ADDR_COUNT_LOW  = 5'h0C;
   localparam logic [4:0] ADDR_COUNT_HIGH = 5'h0D;
   localparam logic [4:0] ADDR_RSVD_FF    = 5'h0E;
   localparam logic [4:0] ADDR_SECONDARY  = 5'h0F;
   localparam logic [4:0] ADDR_UNBACKED   = 5'h14;
   localparam logic [4:0] ADDR_TEMP_OFS   = 5'h18;
   localparam int         CMD_ADDR_MSB    = 7;
   localparam int         CMD_ADDR_LSB    = 3;
   localparam int         CMD_READ_BIT    = 2;
   localparam int         CFG_CLKOUT_EN   = 0;
   localparam int         CFG_TEMP_EN     = 3;
   localparam int         CFG_FREQ_LSB    = 4;
   localparam int         CFG_SWRST       = 6;
   localparam int         CFG_BW          = 7;
   localparam int         ALIGN_SYNC_BIT  = 0;
   localparam logic [7:0] SETUP_RESET     = 8'h00;
   localparam logic [7:0] RSVD_FF_VALUE   = 8'hFF;
   localparam logic [7:0] KEY_UNLOCK      = 8'h9C;
   localparam logic [7:0] KEY_LOCK        = 8'hCA;
   localparam logic [15:0] CRC_POLY       = 16'h1021;
   localparam logic [15:0] CRC_INIT       = 16'hFFFF;
   localparam logic [4:0] LEN_24          = 5'h18;
   localparam logic [4:0] LEN_16          = 5'h10;
   localparam logic [4:0] LEN_8           = 5'h08;
   localparam int         CLK_FREQ_MHZ    = 50;
   localparam int         READY_TIME_US   = 20000;
   localparam int         READY_CYCLES    = READY_TIME_US * CLK_FREQ_MHZ;
   localparam int         DREADY_CYCLES   = 64;
   typedef enum logic [1:0] {PH_CMD, PH_WDATA, PH_RDATA, PH_DONE} spi_phase_t;
endpackage : adc_regs_pkg
`default_nettype wire

// File: spi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
   logic        wr_valid;
   logic [4:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        fetch;
   logic [4:0]  fetch_addr;
   logic [2:0]  fetch_idx;
   logic        rd_ready;
   logic [23:0] rd_word;
   logic [4:0]  rd_len;
   modport engine (output wr_valid, wr_addr, wr_data, fetch, fetch_addr, fetch_idx,
                   input rd_ready, rd_word, rd_len);
   modport bank   (input wr_valid, wr_addr, wr_data, fetch, fetch_addr, fetch_idx,
                   output rd_ready, rd_word, rd_len);
endinterface : spi_link_if
`default_nettype wire

// File: spi_port.sv
`timescale 1ns/1ps
`default_nettype none
module spi_port
(
   input  wire logic   clk,
   input  wire logic   reset,
   input  wire logic   sclk,
   input  wire logic   cs_n,
   input  wire logic   mosi,
   output logic        miso,
   output logic        miso_oe,
   spi_link_if.engine  link
);
   import adc_regs_pkg::*;

   typedef struct packed {
      logic [2:0]  sck_sync;
      logic [2:0]  cs_sync;
      logic [2:0]  mosi_sync;
      logic        sck;
      logic        cs_n;
      logic        mosi;
      spi_phase_t  phase;
      logic [2:0]  bit_cnt;
      logic [7:0]  rx;
      logic [4:0]  addr;
      logic [23:0] tx;
      logic [4:0]  tx_left;
      logic [2:0]  word_idx;
      logic        wr_valid;
      logic [7:0]  wr_data;
      logic        fetch;
      logic        miso;
      logic        miso_oe;
   } engine_state_t;

   localparam engine_state_t ENGINE_RESET = '{sck_sync: 3'h7, cs_sync: 3'h7, sck: 1'b1,
                                              cs_n: 1'b1, phase: PH_CMD, default: '0};

   engine_state_t st;
   engine_state_t next_st;
   logic          rise;
   logic          fall;

   always_comb
   begin
      next_st           = st;
      next_st.wr_valid  = 1'b0;
      next_st.fetch     = 1'b0;
      // three-stage pin filters, a change counts once stages two and three agree
      next_st.sck_sync  = {st.sck_sync[1:0], sclk};
      next_st.cs_sync   = {st.cs_sync[1:0], cs_n};
      next_st.mosi_sync = {st.mosi_sync[1:0], mosi};
      if (st.sck_sync[1] == st.sck_sync[2])
         next_st.sck = st.sck_sync[2];
      if (st.cs_sync[1] == st.cs_sync[2])
         next_st.cs_n = st.cs_sync[2];
      if (st.mosi_sync[1] == st.mosi_sync[2])
         next_st.mosi = st.mosi_sync[2];
      rise = next_st.sck & ~st.sck;
      fall = ~next_st.sck & st.sck;
      if (next_st.cs_n)
      begin
         next_st.phase    = PH_CMD;
         next_st.bit_cnt  = 3'h0;
         next_st.tx_left  = 5'h00;
         next_st.word_idx = 3'h0;
         next_st.miso     = 1'b0;
         next_st.miso_oe  = 1'b0;
      end
      else
      begin
         next_st.miso_oe = 1'b1;
         if (rise && st.phase != PH_RDATA)
         begin
            next_st.rx      = {st.rx[6:0], st.mosi};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'h7)
            begin
               case (st.phase)
                  PH_CMD:
                  begin
                     next_st.addr = next_st.rx[CMD_ADDR_MSB:CMD_ADDR_LSB];
                     if (next_st.rx[CMD_READ_BIT])
                     begin
                        next_st.phase = PH_RDATA;
                        next_st.fetch = 1'b1;
                     end
                     else
                        next_st.phase = PH_WDATA;
                  end
                  PH_WDATA:
                  begin
                     next_st.wr_valid = 1'b1;
                     next_st.wr_data  = next_st.rx;
                     next_st.phase    = PH_DONE;
                  end
                  default:
                     next_st.phase = st.phase;
               endcase
            end
         end
         if (link.rd_ready)
         begin
            next_st.tx      = link.rd_word;
            next_st.tx_left = link.rd_len;
         end
         if (fall && st.phase == PH_RDATA && st.tx_left != 5'h00)
         begin
            next_st.miso    = st.tx[23];
            next_st.tx      = {st.tx[22:0], 1'b0};
            next_st.tx_left = st.tx_left - 5'h01;
            // word done, ask for the next one of a burst
            if (st.tx_left == 5'h01)
            begin
               next_st.fetch = 1'b1;
               if (st.word_idx != 3'h7)
                  next_st.word_idx = st.word_idx + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         st <= ENGINE_RESET;
      else
         st <= next_st;
   end

   assign miso            = st.miso;
   assign miso_oe         = st.miso_oe;
   assign link.wr_valid   = st.wr_valid;
   assign link.wr_addr    = st.addr;
   assign link.wr_data    = st.wr_data;
   assign link.fetch      = st.fetch;
   assign link.fetch_addr = st.addr;
   assign link.fetch_idx  = st.word_idx;
endmodule : spi_port
`default_nettype wire

// File: three_channel_adc_register_map_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_map_asserts
#(
   parameter logic [6:0] DREADY_CYCLES = 7'h40
)
(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       cs_n,
   input wire logic       miso,
   input wire logic       miso_oe,
   input wire logic       sample_valid,
   input wire logic       drdy_n,
   input wire logic       adc_sync,
   input wire logic       soft_reset,
   input wire logic       clkout_en,
   input wire logic       temp_en,
   input wire logic [1:0] adc_freq,
   input wire logic       filter_bw
);
   logic [6:0] low_left;
   // ----
   // cycles of data-ready still owed
   // ----
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         low_left <= 7'h00;
      else if (sample_valid && !clkout_en)
         low_left <= DREADY_CYCLES;
      else if (low_left != 7'h00)
         low_left <= low_left - 7'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_drdy_window; (low_left != 7'h00) == !drdy_n; endproperty
   a_drdy_window: assert property (p_drdy_window) else $error("ready pin window wrong");
   property p_idle_quiet; cs_n [*8] |-> !miso_oe && !miso; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("data out driven while idle");
   property p_frame_drive; !cs_n [*8] |-> miso_oe; endproperty
   a_frame_drive: assert property (p_frame_drive) else $error("data out not enabled");
   property p_sync_pulse; adc_sync |=> !adc_sync; endproperty
   a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
   property p_sync_framed; adc_sync |-> !$past(cs_n, 8); endproperty
   a_sync_framed: assert property (p_sync_framed) else $error("sync without a frame");
   property p_swrst; soft_reset |=> !soft_reset ##2 {filter_bw, adc_freq, temp_en} == 4'h0; endproperty
   a_swrst: assert property (p_swrst) else $error("soft reset misbehaved");
   property p_setup_quiet; cs_n [*8] |=> $stable({filter_bw, adc_freq, temp_en, clkout_en}); endproperty
   a_setup_quiet: assert property (p_setup_quiet) else $error("setup changed while idle");
   property p_reset_defaults; $past(reset) |-> {filter_bw, adc_freq, adc_sync, drdy_n} == 5'h01; endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("bad values after reset");
endmodule : adc_map_asserts
bind three_channel_adc_register_map adc_map_asserts #(.DREADY_CYCLES(DREADY_CYCLES)) adc_map_asserts_inst
(
   .clk(clk), .reset(reset), .cs_n(cs_n), .miso(miso), .miso_oe(miso_oe),
   .sample_valid(sample_valid), .drdy_n(drdy_n), .adc_sync(adc_sync), .soft_reset(soft_reset),
   .clkout_en(clkout_en), .temp_en(temp_en), .adc_freq(adc_freq), .filter_bw(filter_bw)
);
`default_nettype wire

// File: spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
   input  wire logic clk,
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // ----
   // one mode 3 frame, msb first; writes to 0x10 or 0x11 return without a frame
   // ----
   task automatic xfer(input logic [7:0] cmd, input int n, input logic [119:0] wd,
                       output logic [119:0] rd);
      rd = '0;
      if (cmd[7:3] inside {5'h10, 5'h11} && !cmd[2])
         return;
      cs_n <= 1'b0;
      repeat (10) @(posedge clk);
      for (int i = 0; i < 8 + n; i++)
      begin
         sclk <= 1'b0;
         mosi <= (i < 8) ? cmd[7 - i] : wd[n + 7 - i];
         repeat (10) @(posedge clk);
         rd = {rd[118:0], miso};
         sclk <= 1'b1;
         repeat (10) @(posedge clk);
      end
      cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (10) @(posedge clk);
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: three_channel_adc_register_map_test.sv
`timescale 1ns/1ps
`default_nettype none
module three_channel_adc_register_map_test;
   import adc_regs_pkg::*;
   logic         clk, reset, sample_valid, sclk, cs_n, mosi, miso, miso_oe;
   logic         drdy_n, adc_sync, soft_reset, clkout_en, temp_en, filter_bw;
   logic [23:0]  current_in, voltage_one_in, voltage_two_in;
   logic [7:0]   temp_offset_in;
   logic [1:0]   adc_freq;
   logic [119:0] v;
   int           miscompares, checked, syncs, cycles;
   three_channel_adc_register_map #(.READY_CYCLES(4000)) three_channel_adc_register_map_inst
   (
      .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .sample_valid(sample_valid), .current_in(current_in),
      .voltage_one_in(voltage_one_in), .voltage_two_in(voltage_two_in),
      .temp_offset_in(temp_offset_in), .drdy_n(drdy_n), .adc_sync(adc_sync),
      .soft_reset(soft_reset), .clkout_en(clkout_en), .temp_en(temp_en),
      .adc_freq(adc_freq), .filter_bw(filter_bw)
   );
   spi_host_model host_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   // ----
   // helpers
   // ----
   function automatic logic [15:0] crc16(input logic [71:0] d, input int n);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = n - 1; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction : crc16
   task automatic chk(input logic [119:0] got, input logic [119:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rc(input logic [4:0] a, input int n, input logic [119:0] e);
      host_inst.xfer({a, 3'b100}, n, '0, v);
      chk(v & ((120'h1 << n) - 120'h1), e);
   endtask : rc
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host_inst.xfer({a, 3'b000}, 8, {112'h0, d}, v);
   endtask : wr
   task automatic wrap_up;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (adc_sync === 1'b1)
         syncs++;
      if (cycles == 60000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   initial
   begin
      {reset, sample_valid, current_in, voltage_one_in, voltage_two_in} = {2'b10, 72'h0};
      temp_offset_in = 8'hA5;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rc(ADDR_PRIMARY, 8, 8'h01);
      rc(ADDR_CURRENT, 24, 0);
      rc(ADDR_VOLT_TWO, 24, 0);
      rc(ADDR_RSVD_24, 24, 0);
      rc(ADDR_RSVD_16, 16, 0);
      rc(ADDR_SETUP, 8, 0);
      rc(ADDR_SECONDARY, 8, 8'h01);
      rc(ADDR_UNBACKED, 8, 0);
      rc(ADDR_TEMP_OFS, 8, 8'hA5);
      {current_in, voltage_one_in, voltage_two_in} <= 72'h812345_7ABCDE_000F0F;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      @(posedge clk);
      chk(drdy_n, 1'b0);
      wr(ADDR_CURRENT, 8'hFF);
      host_inst.xfer({ADDR_CURRENT, 3'b100}, 120, '0, v);
      chk(v[119:48], 72'h812345_7ABCDE_000F0F);
      chk(v[47:32], crc16(72'h812345_7ABCDE_000F0F, 72));
      chk(v[7:0], 0);
      chk(v[31:8], 24'h000000);
      wr(ADDR_KEY, KEY_LOCK);
      wr(ADDR_SETUP, 8'h38);
      rc(ADDR_SETUP, 8, 0);
      host_inst.xfer({ADDR_PRIMARY, 3'b100}, 8, '0, v);
      chk(v[2], 1'b1);
      wr(ADDR_KEY, KEY_UNLOCK);
      wr(ADDR_SETUP, 8'h38);
      rc(ADDR_SETUP, 8, 8'h38);
      chk({filter_bw, adc_freq, temp_en, clkout_en}, 5'b0_11_1_0);
      rc(ADDR_CONFIG_CRC, 16, crc16({56'h0, 16'h3800}, 16));
      wr(5'h10, 8'h55);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h03);
      wr(ADDR_ALIGN, 8'h01);
      chk(syncs, 1);
      host_inst.xfer({ADDR_CAPTURE, 3'b100}, 16, '0, v);
      chk(v[15:0] inside {[16'h0400:16'h057F]}, 1'b1);
      wr(ADDR_SETUP, 8'h40);
      rc(ADDR_SETUP, 8, 0);
      wrap_up();
   end
endmodule : three_channel_adc_register_map_test
`default_nettype wire
